// File: slc_consts.vh
// constants for the switch lookup and shaper configuration block
`ifndef SLC_CONSTS_VH
`define SLC_CONSTS_VH
// printed offsets are not all multiples of four: they are indices
`define SLC_IDX_SWITCH_OP 12'h0300
`define SLC_IDX_PROVIDER_TAG 12'h030a
`define SLC_IDX_SHAPER_STRAT 12'h030e
`define SLC_IDX_LOOKUP_CTL0 12'h0310
`define SLC_IDX_UNKNOWN_VID 12'h0380
// reset values
`define SLC_RST_PROVIDER_TAG 16'h9100
`define SLC_RST_SHAPER_STRAT 2'h3
`define SLC_RST_LOOKUP_CTL0 8'h61
`define SLC_RST_SWITCH_OP 8'h00
`define SLC_RST_UNKNOWN_VID 1'h0
// field positions
`define SLC_BIT_DOUBLE_TAG 7
`define SLC_BIT_SHAPE_ACCT 1
`define SLC_BIT_POLICE_ACCT 0
`define SLC_BIT_VLAN_EN 7
`define SLC_BIT_DROP_BAD_VID 6
`define SLC_AGE_HI 5
`define SLC_AGE_LO 3
`define SLC_BIT_RSVD_MCAST 2
`define SLC_HASH_HI 1
`define SLC_HASH_LO 0
// hash select encodings
`define SLC_HASH_DIRECT0 2'h0
`define SLC_HASH_CRC 2'h1
`define SLC_HASH_XOR 2'h2
`define SLC_HASH_DIRECT3 2'h3
// gap plus preamble bytes added when an accounting bit is one
`define SLC_OVERHEAD_BYTES 16'h0014
`endif

// File: slc_hash_index.v
// table index generator for the dynamic lookup table
`timescale 1ns/1ps
`include "slc_consts.vh"
module slc_hash_index (
  input wire i_clk, // core clock
  input wire i_srst, // synchronous reset
  input wire [1:0] i_hash_select, // mapping mode
  input wire [47:0] i_dest_addr, // destination address
  output reg [9:0] o_index // registered table index
);
  reg [9:0] crc_idx;
  reg [9:0] xor_idx;
  reg [9:0] index_next;
  integer k;

  always @* begin
    crc_idx = 10'h3ff;
    for (k = 47; k >= 0; k = k - 1) begin
      if (crc_idx[9] ^ i_dest_addr[k])
        crc_idx = {crc_idx[8:0], 1'b0} ^ 10'h233;
      else
        crc_idx = {crc_idx[8:0], 1'b0};
    end
    xor_idx = i_dest_addr[9:0] ^ i_dest_addr[19:10] ^ i_dest_addr[29:20] ^
      i_dest_addr[39:30] ^ {2'h0, i_dest_addr[47:40]};
    case (i_hash_select)
      `SLC_HASH_CRC: index_next = crc_idx;
      `SLC_HASH_XOR: index_next = xor_idx;
      default: index_next = i_dest_addr[9:0];
    endcase
  end

  always @(posedge i_clk) begin
    if (i_srst)
      o_index <= 10'h000;
    else
      o_index <= index_next;
  end
endmodule

// File: slc_top.v
// global lookup, tag and shaper configuration registers with apb access
// What this block does
// - a 16-bit writable provider tag type resets to 9100 and types untagged or outer tags.
// - double tagging counts as active only while the double-tag enable bit is set.
// - shaping accounting bit one charges data plus gap and preamble, zero data only, reset one.
// - policing accounting bit one charges data plus gap and preamble, zero data only, reset one.
// - vlan forwarding and filtering apply only while the vlan enable bit is set, reset zero.
// - drop bit one discards invalid-vid packets, zero sends them to the host port, reset one.
// - enabled unknown-vid forwarding overrides the drop bit for invalid-vid packets.
// - a 3-bit age count in bits 5:3, reset 100, is stamped into each updated dynamic entry.
// - aging time comes from the age count together with the age period.
// - the reserved multicast table is consulted only while its enable bit is set, reset zero.
// - hash select 00 or 11 indexes the table with the ten low destination address bits.
// - hash select 01 uses crc hashing, 10 xor hashing, reset 01.
`timescale 1ns/1ps
`include "slc_consts.vh"
module slc_top (
  input wire I_SYS_CLK, // 25 mhz core clock
  input wire I_SRST, // synchronous reset, high
  input wire I_PSEL, // apb select
  input wire I_PENABLE, // apb enable
  input wire I_PWRITE, // apb direction
  input wire [31:0] I_PADDR, // apb byte address
  input wire [31:0] I_PWDATA, // apb write data
  input wire [3:0] I_PSTRB, // apb byte strobes
  output wire O_PREADY, // apb ready
  output reg [31:0] O_PRDATA, // apb read data
  output wire O_PSLVERR, // apb error
  input wire [47:0] I_DEST_ADDR, // destination address under lookup
  input wire I_FRAME_TAGGED, // received frame carries a tag
  input wire [15:0] I_FRAME_TAG_TYPE, // tag type of received frame
  input wire I_VID_INVALID, // received vid not in vlan table
  input wire [15:0] I_FRAME_BYTES, // frame data bytes to charge
  input wire I_ENTRY_UPDATE, // dynamic entry being written
  input wire [7:0] I_AGE_PERIOD, // age period from its own register
  output wire [9:0] O_TABLE_INDEX, // dynamic table index
  output reg [15:0] O_INGRESS_TAG_TYPE, // tag type to use for frame
  output reg [15:0] O_OUTER_TAG_TYPE, // outer provider tag type
  output reg O_DOUBLE_TAG_ACTIVE, // double tagging active
  output reg O_VLAN_ACTIVE, // vlan forwarding and filtering on
  output reg O_VID_DROP, // discard invalid-vid frame
  output reg O_VID_TO_HOST, // send invalid-vid frame to host
  output reg O_VID_UNKNOWN_FWD, // invalid-vid frame by unknown-vid rule
  output reg O_RSVD_MCAST_LOOKUP, // consult reserved multicast table
  output reg [2:0] O_ENTRY_AGE_COUNT, // age stamped on updated entry
  output reg [10:0] O_AGING_TIME, // age count times age period
  output reg [15:0] O_SHAPER_CHARGE, // bytes charged to shaper
  output reg [15:0] O_POLICER_CHARGE // bytes charged to policer
);
  // gap plus preamble overhead in bytes
  localparam [15:0] OVERHEAD_BYTES = `SLC_OVERHEAD_BYTES;

  reg [15:0] provider_tag_reg;
  reg [1:0] shaper_strat_reg;
  reg [7:0] lookup_ctl0_reg;
  reg [7:0] switch_op_reg;
  reg unknown_vid_reg;
  reg [31:0] rdata_next;
  reg hit;

  wire wr_en = I_PSEL & I_PENABLE & I_PWRITE;
  // read data is loaded in the setup cycle so that it already stands
  // at the access edge, where the master takes it with pready high
  wire rd_en = I_PSEL & ~I_PENABLE & ~I_PWRITE;

  // byte address to register index; misaligned addresses miss
  function is_reg;
    input [31:0] addr;
    input [11:0] idx;
    begin
      is_reg = (addr[1:0] == 2'h0) && (addr[31:14] == 18'h0_0000) &&
        (addr[13:2] == idx);
    end
  endfunction

  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~hit;

  always @* begin
    hit = 1'b1;
    rdata_next = 32'h0000_0000;
    if (is_reg(I_PADDR, `SLC_IDX_PROVIDER_TAG))
      rdata_next = {16'h0000, provider_tag_reg};
    else if (is_reg(I_PADDR, `SLC_IDX_SHAPER_STRAT))
      rdata_next = {30'h0000_0000, shaper_strat_reg};
    else if (is_reg(I_PADDR, `SLC_IDX_LOOKUP_CTL0))
      rdata_next = {24'h00_0000, lookup_ctl0_reg};
    else if (is_reg(I_PADDR, `SLC_IDX_SWITCH_OP))
      rdata_next = {24'h00_0000, switch_op_reg};
    else if (is_reg(I_PADDR, `SLC_IDX_UNKNOWN_VID))
      rdata_next = {31'h0000_0000, unknown_vid_reg};
    else
      hit = 1'b0;
  end

  always @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      provider_tag_reg <= `SLC_RST_PROVIDER_TAG;
      shaper_strat_reg <= `SLC_RST_SHAPER_STRAT;
      lookup_ctl0_reg <= `SLC_RST_LOOKUP_CTL0;
      switch_op_reg <= `SLC_RST_SWITCH_OP;
      unknown_vid_reg <= `SLC_RST_UNKNOWN_VID;
      O_PRDATA <= 32'h0000_0000;
    end else begin
      if (rd_en)
        O_PRDATA <= rdata_next;
      if (wr_en && is_reg(I_PADDR, `SLC_IDX_PROVIDER_TAG)) begin
        if (I_PSTRB[0])
          provider_tag_reg[7:0] <= I_PWDATA[7:0];
        if (I_PSTRB[1])
          provider_tag_reg[15:8] <= I_PWDATA[15:8];
      end
      // only two bits are stored; the rest is dropped
      if (wr_en && is_reg(I_PADDR, `SLC_IDX_SHAPER_STRAT) && I_PSTRB[0])
        shaper_strat_reg <= I_PWDATA[1:0];
      if (wr_en && is_reg(I_PADDR, `SLC_IDX_LOOKUP_CTL0) && I_PSTRB[0])
        lookup_ctl0_reg <= I_PWDATA[7:0];
      // only the double-tag enable is kept in this copy
      if (wr_en && is_reg(I_PADDR, `SLC_IDX_SWITCH_OP) && I_PSTRB[0])
        switch_op_reg <= {I_PWDATA[7], 7'h00};
      if (wr_en && is_reg(I_PADDR, `SLC_IDX_UNKNOWN_VID) && I_PSTRB[0])
        unknown_vid_reg <= I_PWDATA[0];
    end
  end

  slc_hash_index u_hash (
    .i_clk(I_SYS_CLK),
    .i_srst(I_SRST),
    .i_hash_select(lookup_ctl0_reg[`SLC_HASH_HI:`SLC_HASH_LO]),
    .i_dest_addr(I_DEST_ADDR),
    .o_index(O_TABLE_INDEX)
  );

  always @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      O_INGRESS_TAG_TYPE <= 16'h0000;
      O_OUTER_TAG_TYPE <= 16'h0000;
      O_DOUBLE_TAG_ACTIVE <= 1'b0;
      O_VLAN_ACTIVE <= 1'b0;
      O_VID_DROP <= 1'b0;
      O_VID_TO_HOST <= 1'b0;
      O_VID_UNKNOWN_FWD <= 1'b0;
      O_RSVD_MCAST_LOOKUP <= 1'b0;
      O_ENTRY_AGE_COUNT <= 3'h0;
      O_AGING_TIME <= 11'h000;
      O_SHAPER_CHARGE <= 16'h0000;
      O_POLICER_CHARGE <= 16'h0000;
    end else begin
      O_INGRESS_TAG_TYPE <= I_FRAME_TAGGED ? I_FRAME_TAG_TYPE :
        provider_tag_reg;
      O_DOUBLE_TAG_ACTIVE <= switch_op_reg[`SLC_BIT_DOUBLE_TAG];
      O_OUTER_TAG_TYPE <= switch_op_reg[`SLC_BIT_DOUBLE_TAG] ?
        provider_tag_reg : 16'h0000;
      // table contents are software's duty before enabling
      O_VLAN_ACTIVE <= lookup_ctl0_reg[`SLC_BIT_VLAN_EN];
      O_VID_UNKNOWN_FWD <= I_VID_INVALID & unknown_vid_reg;
      O_VID_DROP <= I_VID_INVALID & ~unknown_vid_reg &
        lookup_ctl0_reg[`SLC_BIT_DROP_BAD_VID];
      O_VID_TO_HOST <= I_VID_INVALID & ~unknown_vid_reg &
        ~lookup_ctl0_reg[`SLC_BIT_DROP_BAD_VID];
      O_RSVD_MCAST_LOOKUP <= lookup_ctl0_reg[`SLC_BIT_RSVD_MCAST];
      if (I_ENTRY_UPDATE)
        O_ENTRY_AGE_COUNT <=
          lookup_ctl0_reg[`SLC_AGE_HI:`SLC_AGE_LO];
      O_AGING_TIME <= {8'h00, lookup_ctl0_reg[`SLC_AGE_HI:`SLC_AGE_LO]} *
        {3'h0, I_AGE_PERIOD};
      O_SHAPER_CHARGE <= shaper_strat_reg[`SLC_BIT_SHAPE_ACCT] ?
        I_FRAME_BYTES + OVERHEAD_BYTES : I_FRAME_BYTES;
      O_POLICER_CHARGE <= shaper_strat_reg[`SLC_BIT_POLICE_ACCT] ?
        I_FRAME_BYTES + OVERHEAD_BYTES : I_FRAME_BYTES;
    end
  end
endmodule

// File: slc_top_props.sv
// assertion checker for the configuration register block
`timescale 1ns/1ps
module slc_top_props (
  input wire I_SYS_CLK, // core clock
  input wire I_SRST, // sync reset
  input wire I_PSEL, // apb select
  input wire I_PENABLE, // apb enable
  input wire O_PREADY, // apb ready
  input wire O_PSLVERR, // apb error
  input wire I_VID_INVALID, // bad vid seen
  input wire [15:0] I_FRAME_BYTES, // bytes in
  input wire I_FRAME_TAGGED, // frame tagged
  input wire [15:0] I_FRAME_TAG_TYPE, // frame tag
  input wire I_ENTRY_UPDATE, // entry write
  input wire [2:0] O_ENTRY_AGE_COUNT, // age stamp
  input wire [15:0] O_INGRESS_TAG_TYPE, // ingress tag
  input wire [15:0] O_OUTER_TAG_TYPE, // outer tag
  input wire O_DOUBLE_TAG_ACTIVE, // double tag
  input wire O_VID_DROP, // drop
  input wire O_VID_TO_HOST, // to host
  input wire O_VID_UNKNOWN_FWD, // unknown fwd
  input wire [15:0] O_SHAPER_CHARGE // shaper bytes
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SRST);
  a_ready_always: assert property (O_PREADY)
    else $error("ready low");
  a_err_access: assert property (O_PSLVERR |-> I_PSEL && I_PENABLE)
    else $error("error outside access");
  a_vid_classify: assert property (
    !$past(I_SRST) |-> (O_VID_DROP | O_VID_TO_HOST | O_VID_UNKNOWN_FWD)
    == $past(I_VID_INVALID)) else $error("vid class wrong");
  a_vid_onehot: assert property (
    $onehot0({O_VID_DROP, O_VID_TO_HOST, O_VID_UNKNOWN_FWD}))
    else $error("vid class overlap");
  a_outer_zero: assert property (
    !O_DOUBLE_TAG_ACTIVE |-> O_OUTER_TAG_TYPE == 16'h0000)
    else $error("outer tag while off");
  a_age_hold: assert property (
    !I_ENTRY_UPDATE |=> $stable(O_ENTRY_AGE_COUNT))
    else $error("age moved");
  a_shaper_charge: assert property (
    !$past(I_SRST) |-> O_SHAPER_CHARGE == $past(I_FRAME_BYTES) ||
    O_SHAPER_CHARGE == $past(I_FRAME_BYTES) + 16'h0014)
    else $error("shaper charge wrong");
  a_ingress_tag: assert property (
    !$past(I_SRST) && $past(I_FRAME_TAGGED) |->
    O_INGRESS_TAG_TYPE == $past(I_FRAME_TAG_TYPE))
    else $error("ingress tag wrong");
  c_unknown: cover property (O_VID_UNKNOWN_FWD);
  c_double: cover property (O_DOUBLE_TAG_ACTIVE);
  c_slverr: cover property (O_PSLVERR);
endmodule
bind slc_top slc_top_props i_props (.*);

// File: slc_top_tb.sv
// self-checking bench for the configuration register block
`timescale 1ns/1ps
`include "slc_consts.vh"
module slc_top_tb;
  logic I_SYS_CLK, I_SRST, I_PSEL, I_PENABLE, I_PWRITE, O_PREADY, O_PSLVERR;
  logic [31:0] I_PADDR, I_PWDATA, O_PRDATA, rd;
  logic [3:0] I_PSTRB;
  logic [47:0] I_DEST_ADDR;
  logic I_FRAME_TAGGED, I_VID_INVALID, I_ENTRY_UPDATE, O_DOUBLE_TAG_ACTIVE;
  logic O_VLAN_ACTIVE, O_VID_DROP, O_VID_TO_HOST, O_VID_UNKNOWN_FWD, err;
  logic O_RSVD_MCAST_LOOKUP;
  logic [15:0] I_FRAME_TAG_TYPE, I_FRAME_BYTES, O_INGRESS_TAG_TYPE;
  logic [15:0] O_OUTER_TAG_TYPE, O_SHAPER_CHARGE, O_POLICER_CHARGE;
  logic [7:0] I_AGE_PERIOD;
  logic [9:0] O_TABLE_INDEX;
  logic [2:0] O_ENTRY_AGE_COUNT;
  logic [10:0] O_AGING_TIME;
  int n_fail, n_tests, n;
  slc_top i_dut (.*);
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", s, exp, seen);
    end
  endtask
  // slave answers when it likes; the wait is bounded by the watchdog
  task apb(input logic w, input logic [11:0] ix, input logic [31:0] d);
    @(posedge I_SYS_CLK);
    I_PSEL <= 1;
    I_PWRITE <= w;
    I_PADDR <= {18'h0, ix, 2'b00};
    I_PWDATA <= d;
    @(posedge I_SYS_CLK);
    I_PENABLE <= 1;
    do @(posedge I_SYS_CLK); while (O_PREADY !== 1'b1);
    err = O_PSLVERR;
    rd = O_PRDATA;
    I_PSEL <= 0;
    I_PENABLE <= 0;
  endtask
  task rchk(input string s, input logic [11:0] ix, input logic [31:0] e);
    apb(0, ix, 0);
    chk(s, rd, e);
  endtask
  task tick;
    repeat (3) @(posedge I_SYS_CLK);
  endtask
  initial begin
    I_SYS_CLK = 0;
    forever #20 I_SYS_CLK = ~I_SYS_CLK;
  end
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
  initial begin
    {I_SRST, I_PSEL, I_PENABLE, I_PWRITE, I_FRAME_TAGGED} = 5'b10000;
    {I_VID_INVALID, I_ENTRY_UPDATE, I_PADDR, I_PWDATA, I_PSTRB} = 'hf;
    {I_DEST_ADDR, I_FRAME_TAG_TYPE} = {48'h1234_5678_9abc, 16'h8100};
    {I_FRAME_BYTES, I_AGE_PERIOD} = {16'h0040, 8'h0a};
    n_fail = 0;
    n_tests = 0;
    repeat (3) @(posedge I_SYS_CLK);
    I_SRST <= 0;
    rchk("tag", `SLC_IDX_PROVIDER_TAG, 32'h0000_9100);
    rchk("shaper", `SLC_IDX_SHAPER_STRAT, 32'h0000_0003);
    rchk("ctl0", `SLC_IDX_LOOKUP_CTL0, 32'h0000_0061);
    chk("vlan", O_VLAN_ACTIVE, 0);
    chk("mcast", O_RSVD_MCAST_LOOKUP, 0);
    $display("reset values done");
    apb(1, `SLC_IDX_SHAPER_STRAT, 32'hffff_fffc);
    rchk("shaper", `SLC_IDX_SHAPER_STRAT, 32'h0000_0000);
    for (int s = 0; s < 4; s++) begin
      apb(1, `SLC_IDX_SHAPER_STRAT, s);
      tick();
      chk("shape", O_SHAPER_CHARGE, s[1] ? 84 : 64);
      chk("police", O_POLICER_CHARGE, s[0] ? 84 : 64);
    end
    $display("shaper done");
    I_PSTRB <= 4'h1;
    apb(1, `SLC_IDX_PROVIDER_TAG, 32'h0000_aaaa);
    I_PSTRB <= 4'hf;
    rchk("tag", `SLC_IDX_PROVIDER_TAG, 32'h0000_91aa);
    apb(1, `SLC_IDX_SWITCH_OP, 32'h0000_0080);
    tick();
    chk("dbl", O_DOUBLE_TAG_ACTIVE, 1);
    chk("outer", O_OUTER_TAG_TYPE, 32'h0000_91aa);
    chk("ingress", O_INGRESS_TAG_TYPE, 32'h0000_91aa);
    I_FRAME_TAGGED <= 1;
    tick();
    chk("ingress", O_INGRESS_TAG_TYPE, 32'h0000_8100);
    $display("tag done");
    I_VID_INVALID <= 1;
    apb(1, `SLC_IDX_LOOKUP_CTL0, 32'h0000_00ac);
    I_ENTRY_UPDATE <= 1;
    @(posedge I_SYS_CLK);
    I_ENTRY_UPDATE <= 0;
    tick();
    chk("vlan", O_VLAN_ACTIVE, 1);
    chk("mcast", O_RSVD_MCAST_LOOKUP, 1);
    chk("host", O_VID_TO_HOST, 1);
    chk("age", O_ENTRY_AGE_COUNT, 5);
    chk("aging", O_AGING_TIME, 50);
    chk("index", O_TABLE_INDEX, 32'h0000_02bc);
    for (int h = 1; h < 4; h++) begin
      apb(1, `SLC_IDX_LOOKUP_CTL0, 32'h0000_00c0 | h);
      rchk("ctl0", `SLC_IDX_LOOKUP_CTL0, 32'h0000_00c0 | h);
      chk("drop", O_VID_DROP, 1);
      // xor of four 10-bit address slices and the zero-extended top 8 bits
      if (h == 2)
        chk("xor", O_TABLE_INDEX, 32'h0000_013e);
    end
    chk("index", O_TABLE_INDEX, 32'h0000_02bc);
    apb(1, `SLC_IDX_UNKNOWN_VID, 1);
    tick();
    chk("unknown", {O_VID_UNKNOWN_FWD, O_VID_DROP}, 2);
    $display("lookup done");
    apb(0, 12'h040, 0);
    chk("slverr", err, 1);
    chk("rdzero", rd, 0);
    $display("unmapped done");
    stop_test();
  end
endmodule
